// ==== hdl/port_one_control.sv ====
// Switch port one control: classification, tagging, filtering and forwarding decisions
// How it works
// RQ1 - Port priority used when classification absent
// RQ2 - Tag and code-point OR overrides port
// RQ3 - Insert tag on egress for untagged
// RQ4 - Inserted tag uses ingress port VID
// RQ5 - Strip tag on egress for tagged
// RQ6 - Multi-queue bit gives four queues
// RQ7 - Otherwise single queue, priority ignored
// RQ8 - Drop when VLAN membership lacks port
// RQ9 - Drop non-default VID when enabled
// RQ10 - Force flow control overrides negotiation
// RQ11 - Back pressure only when enabled
// RQ12 - Transmit only while transmit enabled
// RQ13 - Receive only while receive enabled
// RQ14 - Learning stops when disable set
// RQ15 - Sniffer port transmits monitored packets
// RQ16 - Receive monitor marks and mirrors
// RQ17 - Transmit monitor marks and mirrors
// RQ18 - Ceiling caps priority at user priority
// RQ19 - Membership mask bits select ports
// RQ20 - Forward only to member ports
// RQ21 - Default VID is tag bits 11-0
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module switch_port_one_control (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Avalon-MM slave
  input wire logic [8:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [1:0] i_byteenable,
  input wire logic [15:0] i_writedata,
  output logic [15:0] o_readdata,
  output logic o_waitrequest,
  // Ingress classification request
  input wire logic i_in_valid,
  input wire logic i_in_tagged,
  input wire logic [11:0] i_in_vid,
  input wire logic i_tagp_ok,
  input wire logic [1:0] i_tagp_pri,
  input wire logic i_dsc_ok,
  input wire logic [1:0] i_dsc_pri,
  input wire logic [2:0] i_pkt_user_pri,
  input wire logic [2:0] i_vlan_members,
  input wire logic [2:0] i_in_port,
  // Ingress decision
  output logic o_in_valid,
  output logic o_in_drop,
  output logic [1:0] o_in_queue_pri,
  output logic [2:0] o_in_user_pri,
  output logic o_in_learn,
  output logic o_in_monitored,
  output logic [2:0] o_fwd_mask,
  // Egress request
  input wire logic i_eg_valid,
  input wire logic i_eg_was_tagged,
  input wire logic [11:0] i_eg_src_vid,
  input wire logic [1:0] i_eg_pri,
  input wire logic i_eg_monitored,
  // Egress decision
  output logic o_eg_valid,
  output logic o_eg_send,
  output logic o_eg_insert,
  output logic o_eg_strip,
  output logic [11:0] o_eg_tag_vid,
  output logic [1:0] o_eg_queue,
  output logic o_eg_mirror,
  // Port MAC controls
  input wire logic i_an_flow_ctrl,
  output logic o_flow_ctrl,
  output logic o_back_pressure,
  output logic o_tx_enable,
  output logic o_rx_enable,
  output logic o_sniffer_port
);
  logic [15:0] ctrl_a;
  logic [15:0] ctrl_b;
  logic [15:0] tag;
  logic [11:0] port_default_vlan_id;
  logic [2:0] up_ceiling;
  logic [1:0] cls_pri;
  logic cls_ok;
  logic [1:0] pri_d;
  logic [2:0] up_d;
  logic drop_d;
  logic [2:0] mem;

  logic in_v_q;
  logic in_drop_q;
  logic [1:0] in_pri_q;
  logic [2:0] in_up_q;
  logic in_learn_q;
  logic in_mon_q;
  logic [2:0] fwd_q;
  logic eg_v_q;
  logic eg_send_q;
  logic eg_ins_q;
  logic eg_strip_q;
  logic [11:0] eg_vid_q;
  logic [1:0] eg_q_q;
  logic eg_mir_q;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  port_one_regs regs (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_address(i_address),
    .i_read(i_read),
    .i_write(i_write),
    .i_byteenable(i_byteenable),
    .i_writedata(i_writedata),
    .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest),
    .o_ctrl_a(ctrl_a),
    .o_ctrl_b(ctrl_b),
    .o_tag(tag)
  );

  assign port_default_vlan_id = tag[port_one_pkg::t_vid_hi:0]; // RQ21
  assign up_ceiling = tag[port_one_pkg::t_up_hi:port_one_pkg::t_up_lo];
  assign mem = ctrl_b[port_one_pkg::b_mem_hi:0]; // RQ19

  // ---------------------------------------------------------------
  // Ingress classification
  // ---------------------------------------------------------------
  always_comb begin
    cls_ok = 1'b0;
    cls_pri = 2'h0;
    if (ctrl_a[port_one_pkg::a_tagp_en] & i_tagp_ok) begin
      cls_ok = 1'b1;
      cls_pri = cls_pri | i_tagp_pri; // RQ2
    end
    if (ctrl_a[port_one_pkg::a_dsc_en] & i_dsc_ok) begin
      cls_ok = 1'b1;
      cls_pri = cls_pri | i_dsc_pri; // RQ2
    end
    if (cls_ok) begin
      pri_d = cls_pri;
    end else begin
      pri_d = ctrl_a[port_one_pkg::a_pri_hi:port_one_pkg::a_pri_lo]; // RQ1
    end
    if (ctrl_b[port_one_pkg::b_ceil] && (i_pkt_user_pri > up_ceiling)) begin
      up_d = up_ceiling; // RQ18
    end else begin
      up_d = i_pkt_user_pri;
    end
    drop_d = 1'b0;
    if (!ctrl_b[port_one_pkg::b_rx]) begin
      drop_d = 1'b1; // RQ13
    end
    if (ctrl_b[port_one_pkg::b_vf] && ((i_vlan_members & i_in_port) == 3'h0)) begin
      drop_d = 1'b1; // RQ8
    end
    // Untagged arrivals take the default VID, so they never mismatch
    if (ctrl_b[port_one_pkg::b_npvid] && i_in_tagged && (i_in_vid != port_default_vlan_id)) begin
      drop_d = 1'b1; // RQ9
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      in_v_q <= 1'b0;
      in_drop_q <= 1'b0;
      in_pri_q <= 2'h0;
      in_up_q <= 3'h0;
      in_learn_q <= 1'b0;
      in_mon_q <= 1'b0;
      fwd_q <= 3'h0;
    end else begin
      in_v_q <= i_in_valid;
      if (i_in_valid) begin
        in_drop_q <= drop_d;
        in_pri_q <= pri_d;
        in_up_q <= up_d;
        in_learn_q <= ~drop_d & ~ctrl_b[port_one_pkg::b_nolearn]; // RQ14
        in_mon_q <= ~drop_d & ctrl_b[port_one_pkg::b_rxmon]; // RQ16
        fwd_q <= drop_d ? 3'h0 : mem; // RQ20
      end
    end
  end

  assign o_in_valid = in_v_q;
  assign o_in_drop = in_drop_q;
  assign o_in_queue_pri = in_pri_q;
  assign o_in_user_pri = in_up_q;
  assign o_in_learn = in_learn_q;
  assign o_in_monitored = in_mon_q;
  assign o_fwd_mask = fwd_q;

  // ---------------------------------------------------------------
  // Egress decision
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      eg_v_q <= 1'b0;
      eg_send_q <= 1'b0;
      eg_ins_q <= 1'b0;
      eg_strip_q <= 1'b0;
      eg_vid_q <= 12'h000;
      eg_q_q <= 2'h0;
      eg_mir_q <= 1'b0;
    end else begin
      eg_v_q <= i_eg_valid;
      if (i_eg_valid) begin
        eg_send_q <= ctrl_b[port_one_pkg::b_tx]; // RQ12
        eg_ins_q <= ctrl_a[port_one_pkg::a_ins] & ~i_eg_was_tagged; // RQ3
        eg_strip_q <= ctrl_a[port_one_pkg::a_strip] & i_eg_was_tagged; // RQ5
        eg_vid_q <= i_eg_src_vid; // RQ4
        eg_q_q <= ctrl_a[port_one_pkg::a_mq] ? i_eg_pri : 2'h0; // RQ6 RQ7
        eg_mir_q <= ctrl_b[port_one_pkg::b_tx] & ctrl_b[port_one_pkg::b_txmon]; // RQ17
      end
    end
  end

  assign o_eg_valid = eg_v_q;
  assign o_eg_send = eg_send_q;
  assign o_eg_insert = eg_ins_q;
  assign o_eg_strip = eg_strip_q;
  assign o_eg_tag_vid = eg_vid_q;
  assign o_eg_queue = eg_q_q;
  assign o_eg_mirror = eg_mir_q;

  // ---------------------------------------------------------------
  // Port MAC controls
  // ---------------------------------------------------------------
  assign o_flow_ctrl = ctrl_b[port_one_pkg::b_ffc] | i_an_flow_ctrl; // RQ10
  assign o_back_pressure = ctrl_b[port_one_pkg::b_bp]; // RQ11
  assign o_tx_enable = ctrl_b[port_one_pkg::b_tx]; // RQ12
  assign o_rx_enable = ctrl_b[port_one_pkg::b_rx]; // RQ13
  assign o_sniffer_port = ctrl_b[port_one_pkg::b_sniffer]; // RQ15

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Request and answer one cycle apart
  sequence s_in_req;
    i_in_valid;
  endsequence
  sequence s_eg_req;
    i_eg_valid;
  endsequence
  sequence s_in_kept;
    s_in_req ##1 (o_in_valid && !o_in_drop);
  endsequence
  sequence s_in_dropped;
    s_in_req ##1 (o_in_valid && o_in_drop);
  endsequence
  a_port_pri_default: assert property (@(posedge i_clock) disable iff (i_rst) // RQ1
    (i_in_valid && !cls_ok) |=> (o_in_queue_pri == $past(ctrl_a[4:3])))
    else $error("port priority not applied");
  a_cls_or_pri: assert property (@(posedge i_clock) disable iff (i_rst) // RQ2
    (i_in_valid && ctrl_a[5] && ctrl_a[6] && i_tagp_ok && i_dsc_ok)
    |=> (o_in_queue_pri == ($past(i_tagp_pri) | $past(i_dsc_pri))))
    else $error("classification OR wrong");
  a_insert_untag: assert property (@(posedge i_clock) disable iff (i_rst) // RQ3
    i_eg_valid |=> (o_eg_insert == ($past(ctrl_a[2]) && !$past(i_eg_was_tagged))))
    else $error("tag insert wrong");
  a_insert_vid: assert property (@(posedge i_clock) disable iff (i_rst) // RQ4
    i_eg_valid |=> (o_eg_tag_vid == $past(i_eg_src_vid)))
    else $error("inserted VID wrong");
  a_strip_tagged: assert property (@(posedge i_clock) disable iff (i_rst) // RQ5
    i_eg_valid |=> (o_eg_strip == ($past(ctrl_a[1]) && $past(i_eg_was_tagged))))
    else $error("tag strip wrong");
  a_single_queue: assert property (@(posedge i_clock) disable iff (i_rst) // RQ7
    (i_eg_valid && !ctrl_a[0]) |=> (o_eg_queue == 2'h0))
    else $error("single queue not used");
  a_multi_queue: assert property (@(posedge i_clock) disable iff (i_rst) // RQ6
    (i_eg_valid && ctrl_a[0]) |=> (o_eg_queue == $past(i_eg_pri)))
    else $error("queue select wrong");
  a_vlan_filter: assert property (@(posedge i_clock) disable iff (i_rst) // RQ8
    (i_in_valid && ctrl_b[14] && ((i_vlan_members & i_in_port) == 3'h0)) |=> o_in_drop)
    else $error("VLAN filter missed");
  a_port_default_vlan_id_drop: assert property (@(posedge i_clock) disable iff (i_rst) // RQ9
    (i_in_valid && i_in_tagged && ctrl_b[13] && (i_in_vid != tag[11:0]))
    |=> (o_in_drop && (o_fwd_mask == 3'h0)))
    else $error("non default VID kept");
  a_rx_disable: assert property (@(posedge i_clock) disable iff (i_rst) // RQ13
    (i_in_valid && !ctrl_b[9]) |=> (o_in_drop && !o_in_learn))
    else $error("receive disabled not dropped");
  a_tx_disable: assert property (@(posedge i_clock) disable iff (i_rst) // RQ12
    (i_eg_valid && !ctrl_b[10]) |=> (!o_eg_send && !o_eg_mirror))
    else $error("transmit while disabled");
  a_pri_ceiling: assert property (@(posedge i_clock) disable iff (i_rst) // RQ18
    (i_in_valid && ctrl_b[3]) |=> (o_in_user_pri <= $past(tag[15:13])))
    else $error("ceiling exceeded");
  a_fwd_member: assert property (@(posedge i_clock) disable iff (i_rst) // RQ20
    o_in_valid |-> ((o_fwd_mask & ~ctrl_b[2:0]) == 3'h0) || $changed(ctrl_b))
    else $error("forward outside membership");

  // ---------------------------------------------------------------
  // Handshake, marking and level checks
  // ---------------------------------------------------------------
  a_in_answer: assert property (@(posedge i_clock) disable iff (i_rst)
    s_in_req |=> o_in_valid)
    else $error("ingress answer missing");
  a_eg_answer: assert property (@(posedge i_clock) disable iff (i_rst)
    s_eg_req |=> o_eg_valid)
    else $error("egress answer missing");
  a_wait_once: assert property (@(posedge i_clock) disable iff (i_rst)
    o_waitrequest |=> !o_waitrequest)
    else $error("more than one wait cycle");
  a_learn_rule: assert property (@(posedge i_clock) disable iff (i_rst) // RQ14
    s_in_req |=> (o_in_learn == (!o_in_drop && !$past(ctrl_b[port_one_pkg::b_nolearn]))))
    else $error("learning flag wrong");
  a_rx_monitor: assert property (@(posedge i_clock) disable iff (i_rst) // RQ16
    s_in_req |=> (o_in_monitored == (!o_in_drop && $past(ctrl_b[port_one_pkg::b_rxmon]))))
    else $error("receive monitor mark wrong");
  a_tx_monitor: assert property (@(posedge i_clock) disable iff (i_rst) // RQ17
    s_eg_req |=> (o_eg_mirror == ($past(ctrl_b[port_one_pkg::b_tx]) && $past(ctrl_b[port_one_pkg::b_txmon]))))
    else $error("transmit monitor mark wrong");
  a_member_keep: assert property (@(posedge i_clock) disable iff (i_rst) // RQ19
    s_in_kept |-> (o_fwd_mask == $past(ctrl_b[port_one_pkg::b_mem_hi:0])))
    else $error("kept packet mask not membership");
  a_drop_clean: assert property (@(posedge i_clock) disable iff (i_rst) // RQ20
    s_in_dropped |-> ((o_fwd_mask == 3'h0) && !o_in_learn && !o_in_monitored))
    else $error("dropped packet still forwarded");
  a_vid_match: assert property (@(posedge i_clock) disable iff (i_rst) // RQ21
    (i_in_valid && i_in_tagged && ctrl_b[port_one_pkg::b_rx] && !ctrl_b[port_one_pkg::b_vf]
     && (i_in_vid == tag[port_one_pkg::t_vid_hi:0])) |=> !o_in_drop)
    else $error("default VID packet dropped");
  a_untag_keep: assert property (@(posedge i_clock) disable iff (i_rst) // RQ9
    (i_in_valid && !i_in_tagged && ctrl_b[port_one_pkg::b_rx] && !ctrl_b[port_one_pkg::b_vf]) |=> !o_in_drop)
    else $error("untagged packet dropped");
  a_tx_send: assert property (@(posedge i_clock) disable iff (i_rst) // RQ12
    (i_eg_valid && ctrl_b[port_one_pkg::b_tx]) |=> o_eg_send)
    else $error("transmit enabled but not sent");
  a_ceil_off: assert property (@(posedge i_clock) disable iff (i_rst) // RQ18
    (i_in_valid && !ctrl_b[port_one_pkg::b_ceil]) |=> (o_in_user_pri == $past(i_pkt_user_pri)))
    else $error("priority changed without ceiling");
  a_force_flow: assert property (@(posedge i_clock) disable iff (i_rst) // RQ10
    ctrl_b[port_one_pkg::b_ffc] |-> o_flow_ctrl)
    else $error("forced flow control off");
  a_auto_flow: assert property (@(posedge i_clock) disable iff (i_rst) // RQ10
    !ctrl_b[port_one_pkg::b_ffc] |-> (o_flow_ctrl == i_an_flow_ctrl))
    else $error("flow control not from negotiation");
  a_one_edit: assert property (@(posedge i_clock) disable iff (i_rst) // RQ3
    o_eg_valid |-> !(o_eg_insert && o_eg_strip))
    else $error("insert and strip together");
  a_sniff_level: assert property (@(posedge i_clock) disable iff (i_rst) // RQ15
    o_sniffer_port == ctrl_b[port_one_pkg::b_sniffer])
    else $error("sniffer flag wrong");
  a_bp_level: assert property (@(posedge i_clock) disable iff (i_rst) // RQ11
    o_back_pressure == ctrl_b[port_one_pkg::b_bp])
    else $error("back pressure flag wrong");
endmodule
`default_nettype wire

// ==== hdl/port_one_pkg.sv ====
// Constants for the switch port one control block
package port_one_pkg;
  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [8:0] ctrl_a_idx = 9'h06C;
  localparam logic [8:0] ctrl_b_idx = 9'h06E;
  localparam logic [8:0] tag_idx = 9'h070;
  // ---------------------------------------------------------------
  // Control A fields
  // ---------------------------------------------------------------
  localparam int a_dsc_en = 6;
  localparam int a_tagp_en = 5;
  localparam int a_pri_hi = 4;
  localparam int a_pri_lo = 3;
  localparam int a_ins = 2;
  localparam int a_strip = 1;
  localparam int a_mq = 0;
  localparam logic [15:0] a_rw_mask = 16'h007F;
  localparam logic [15:0] a_reset = 16'h0000;
  // ---------------------------------------------------------------
  // Control B fields
  // ---------------------------------------------------------------
  localparam int b_vf = 14;
  localparam int b_npvid = 13;
  localparam int b_ffc = 12;
  localparam int b_bp = 11;
  localparam int b_tx = 10;
  localparam int b_rx = 9;
  localparam int b_nolearn = 8;
  localparam int b_sniffer = 7;
  localparam int b_rxmon = 6;
  localparam int b_txmon = 5;
  localparam int b_ceil = 3;
  localparam int b_mem_hi = 2;
  localparam logic [15:0] b_reset = 16'h0607;
  // ---------------------------------------------------------------
  // Default tag fields
  // ---------------------------------------------------------------
  localparam int t_up_hi = 15;
  localparam int t_up_lo = 13;
  localparam int t_vid_hi = 11;
  localparam logic [15:0] t_reset = 16'h0001;
endpackage

// ==== hdl/port_one_regs.sv ====
// Avalon-MM slave register file for the port one control block
`timescale 1ns/100ps
`default_nettype none
module port_one_regs (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Avalon-MM slave
  input wire logic [8:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [1:0] i_byteenable,
  input wire logic [15:0] i_writedata,
  output logic [15:0] o_readdata,
  output logic o_waitrequest,
  // Register contents
  output logic [15:0] o_ctrl_a,
  output logic [15:0] o_ctrl_b,
  output logic [15:0] o_tag
);
  logic done_q;
  logic [15:0] a_q;
  logic [15:0] b_q;
  logic [15:0] t_q;
  logic [15:0] rd_d;
  logic [15:0] rd_q;
  logic [15:0] mask;
  logic hit;

  // ---------------------------------------------------------------
  // Handshake: one wait cycle, answer on the second
  // ---------------------------------------------------------------
  assign hit = (i_read | i_write) & done_q;
  assign o_waitrequest = (i_read | i_write) & ~done_q;
  assign mask = {{8{i_byteenable[1]}}, {8{i_byteenable[0]}}};

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (i_read | i_write) & ~done_q;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      a_q <= port_one_pkg::a_reset;
      b_q <= port_one_pkg::b_reset;
      t_q <= port_one_pkg::t_reset;
    end else if (hit & i_write) begin
      if (i_address == port_one_pkg::ctrl_a_idx) begin
        a_q <= ((a_q & ~mask) | (i_writedata & mask)) & port_one_pkg::a_rw_mask;
      end else if (i_address == port_one_pkg::ctrl_b_idx) begin
        b_q <= (b_q & ~mask) | (i_writedata & mask);
      end else if (i_address == port_one_pkg::tag_idx) begin
        t_q <= (t_q & ~mask) | (i_writedata & mask);
      end
    end
  end

  // Unmapped addresses read zero and ignore writes
  always_comb begin
    if (i_address == port_one_pkg::ctrl_a_idx) begin
      rd_d = a_q;
    end else if (i_address == port_one_pkg::ctrl_b_idx) begin
      rd_d = b_q;
    end else if (i_address == port_one_pkg::tag_idx) begin
      rd_d = t_q;
    end else begin
      rd_d = 16'h0000;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rd_q <= 16'h0000;
    end else if (i_read & ~done_q) begin
      rd_q <= rd_d;
    end
  end

  assign o_readdata = rd_q;
  assign o_ctrl_a = a_q;
  assign o_ctrl_b = b_q;
  assign o_tag = t_q;
endmodule
`default_nettype wire

// ==== tb/test_switch_port_one_control.sv ====
// Self-checking testbench for the switch port one control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module test_switch_port_one_control;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic i_clock = 1'b0, i_rst = 1'b1;
  logic [8:0] i_address = 9'h000;
  logic i_read = 1'b0, i_write = 1'b0;
  logic [1:0] i_byteenable = 2'h3;
  logic [15:0] i_writedata = 16'h0000, o_readdata;
  logic o_waitrequest, i_in_valid = 1'b0, i_in_tagged = 1'b1, i_tagp_ok = 1'b0, i_dsc_ok = 1'b0;
  logic [11:0] i_in_vid = 12'h001, i_eg_src_vid = 12'h000, o_eg_tag_vid;
  logic [1:0] i_tagp_pri = 2'h0, i_dsc_pri = 2'h0, i_eg_pri = 2'h0, o_in_queue_pri, o_eg_queue;
  logic [2:0] i_pkt_user_pri = 3'h0, i_vlan_members = 3'h7, i_in_port = 3'h1, o_in_user_pri, o_fwd_mask;
  logic o_in_valid, o_in_drop, o_in_learn, o_in_monitored;
  logic i_eg_valid = 1'b0, i_eg_was_tagged = 1'b0, i_eg_monitored = 1'b0, i_an_flow_ctrl = 1'b0;
  logic o_eg_valid, o_eg_send, o_eg_insert, o_eg_strip, o_eg_mirror;
  logic o_flow_ctrl, o_back_pressure, o_tx_enable, o_rx_enable, o_sniffer_port;
  int errors = 0, compares = 0, cycles = 0;
  localparam logic [8:0] ra = port_one_pkg::ctrl_a_idx;
  localparam logic [8:0] rb = port_one_pkg::ctrl_b_idx;
  localparam logic [8:0] rt = port_one_pkg::tag_idx;

  switch_port_one_control dut (
    .i_clock, .i_rst, .i_address, .i_read, .i_write, .i_byteenable, .i_writedata, .o_readdata,
    .o_waitrequest, .i_in_valid, .i_in_tagged, .i_in_vid, .i_tagp_ok, .i_tagp_pri, .i_dsc_ok,
    .i_dsc_pri, .i_pkt_user_pri, .i_vlan_members, .i_in_port, .o_in_valid, .o_in_drop,
    .o_in_queue_pri, .o_in_user_pri, .o_in_learn, .o_in_monitored, .o_fwd_mask, .i_eg_valid,
    .i_eg_was_tagged, .i_eg_src_vid, .i_eg_pri, .i_eg_monitored, .o_eg_valid, .o_eg_send,
    .o_eg_insert, .o_eg_strip, .o_eg_tag_vid, .o_eg_queue, .o_eg_mirror, .i_an_flow_ctrl,
    .o_flow_ctrl, .o_back_pressure, .o_tx_enable, .o_rx_enable, .o_sniffer_port
  );

  always #4 i_clock = ~i_clock;

  // Hang guard
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      report_and_stop();
    end
  end

  task report_and_stop;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Drivers
  // ---------------------------------------------------------------
  task automatic xfer(input logic w, input logic [8:0] a, input logic [15:0] d, output logic [15:0] q);
    int n;
    n = 0;
    @(posedge i_clock);
    i_address <= a;
    i_write <= w;
    i_read <= !w;
    i_writedata <= d;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 40);
    `CHK("waitrequest", 1'b0, o_waitrequest)
    q = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask

  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    logic [15:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string n, input logic [8:0] a, input logic [15:0] e);
    logic [15:0] q;
    xfer(1'b0, a, 16'h0000, q);
    `CHK(n, e, q)
  endtask

  task automatic ing(input logic [11:0] vid, input logic tok, input logic [1:0] tp, input logic dok,
                     input logic [1:0] dp, input logic [2:0] up, input logic [2:0] mem);
    @(posedge i_clock);
    i_in_vid <= vid;
    i_tagp_ok <= tok;
    i_tagp_pri <= tp;
    i_dsc_ok <= dok;
    i_dsc_pri <= dp;
    i_pkt_user_pri <= up;
    i_vlan_members <= mem;
    i_in_valid <= 1'b1;
    @(posedge i_clock);
    i_in_valid <= 1'b0;
    @(posedge i_clock);
    `CHK("o_in_valid", 1'b1, o_in_valid)
  endtask

  task automatic eg(input logic tg, input logic [11:0] vid, input logic [1:0] p);
    @(posedge i_clock);
    i_eg_was_tagged <= tg;
    i_eg_src_vid <= vid;
    i_eg_pri <= p;
    i_eg_valid <= 1'b1;
    @(posedge i_clock);
    i_eg_valid <= 1'b0;
    @(posedge i_clock);
    `CHK("o_eg_valid", 1'b1, o_eg_valid)
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd_chk("ctrl_a", ra, 16'h0000);
    rd_chk("ctrl_b", rb, 16'h0607);
    rd_chk("tag", rt, 16'h0001);
    `CHK("tx_en", 1'b1, o_tx_enable)
    `CHK("rx_en", 1'b1, o_rx_enable)
    wr(9'h072, 16'hFFFF);
    rd_chk("unmapped", 9'h072, 16'h0000);
    wr(ra, 16'hFFFF);
    rd_chk("ctrl_a_mask", ra, 16'h007F);
    i_byteenable <= 2'h1;
    wr(rt, 16'h5A5A);
    i_byteenable <= 2'h3;
    rd_chk("tag_lane", rt, 16'h005A);
    wr(rt, 16'h0001);
  endtask

  task automatic t_prio;
    for (int p = 0; p < 4; p++) begin
      wr(ra, 16'(p << 3));
      ing(12'h001, 1'b1, 2'h3, 1'b1, 2'h3, 3'h0, 3'h7);
      `CHK("port_pri", 2'(p), o_in_queue_pri)
    end
    wr(ra, 16'h0060);
    ing(12'h001, 1'b1, 2'h1, 1'b1, 2'h2, 3'h0, 3'h7);
    `CHK("or_pri", 2'h3, o_in_queue_pri)
    ing(12'h001, 1'b0, 2'h3, 1'b1, 2'h1, 3'h0, 3'h7);
    `CHK("dsc_pri", 2'h1, o_in_queue_pri)
    wr(ra, 16'h0028);
    ing(12'h001, 1'b0, 2'h2, 1'b0, 2'h2, 3'h0, 3'h7);
    `CHK("fail_pri", 2'h1, o_in_queue_pri)
  endtask

  task automatic t_egress;
    wr(ra, 16'h0007);
    wr(rb, 16'h0627);
    for (int p = 0; p < 4; p++) begin
      eg(1'b0, 12'h35A, 2'(p));
      `CHK("insert", 1'b1, o_eg_insert)
      `CHK("strip_u", 1'b0, o_eg_strip)
      `CHK("tag_vid", 12'h35A, o_eg_tag_vid)
      `CHK("queue", 2'(p), o_eg_queue)
      `CHK("mirror", 1'b1, o_eg_mirror)
    end
    eg(1'b1, 12'h35A, 2'h2);
    `CHK("insert_t", 1'b0, o_eg_insert)
    `CHK("strip", 1'b1, o_eg_strip)
    wr(ra, 16'h0000);
    eg(1'b1, 12'h35A, 2'h3);
    `CHK("one_queue", 2'h0, o_eg_queue)
    `CHK("no_strip", 1'b0, o_eg_strip)
    `CHK("send", 1'b1, o_eg_send)
    wr(rb, 16'h0207);
    eg(1'b0, 12'h35A, 2'h1);
    `CHK("no_send", 1'b0, o_eg_send)
    `CHK("tx_off", 1'b0, o_tx_enable)
    `CHK("no_mirror", 1'b0, o_eg_mirror)
  endtask

  task automatic t_filter;
    wr(rb, 16'h4605);
    ing(12'h001, 1'b0, 2'h0, 1'b0, 2'h0, 3'h0, 3'h6);
    `CHK("vf_drop", 1'b1, o_in_drop)
    `CHK("vf_fwd", 3'h0, o_fwd_mask)
    ing(12'h001, 1'b0, 2'h0, 1'b0, 2'h0, 3'h0, 3'h3);
    `CHK("vf_keep", 1'b0, o_in_drop)
    `CHK("no_mon", 1'b0, o_in_monitored)
    `CHK("fwd", 3'h5, o_fwd_mask)
    `CHK("learn", 1'b1, o_in_learn)
    wr(rb, 16'h2747);
    ing(12'h002, 1'b0, 2'h0, 1'b0, 2'h0, 3'h0, 3'h7);
    `CHK("port_default_vlan_id_drop", 1'b1, o_in_drop)
    i_in_tagged <= 1'b0;
    ing(12'h002, 1'b0, 2'h0, 1'b0, 2'h0, 3'h0, 3'h7);
    `CHK("untag_keep", 1'b0, o_in_drop)
    i_in_tagged <= 1'b1;
    ing(12'h001, 1'b0, 2'h0, 1'b0, 2'h0, 3'h0, 3'h7);
    `CHK("port_default_vlan_id_keep", 1'b0, o_in_drop)
    `CHK("nolearn", 1'b0, o_in_learn)
    `CHK("rx_mon", 1'b1, o_in_monitored)
    wr(rt, 16'h6ABC);
    wr(rb, 16'h260F);
    ing(12'hABC, 1'b0, 2'h0, 1'b0, 2'h0, 3'h7, 3'h7);
    `CHK("port_default_vlan_id_new", 1'b0, o_in_drop)
    `CHK("ceil", 3'h3, o_in_user_pri)
    ing(12'hABC, 1'b0, 2'h0, 1'b0, 2'h0, 3'h2, 3'h7);
    `CHK("below_ceil", 3'h2, o_in_user_pri)
    wr(rb, 16'h0607);
    ing(12'h001, 1'b0, 2'h0, 1'b0, 2'h0, 3'h7, 3'h7);
    `CHK("no_ceil", 3'h7, o_in_user_pri)
    `CHK("npvid_off", 1'b0, o_in_drop)
    wr(rb, 16'h0407);
    ing(12'h001, 1'b0, 2'h0, 1'b0, 2'h0, 3'h0, 3'h7);
    `CHK("rx_drop", 1'b1, o_in_drop)
    `CHK("rx_off", 1'b0, o_rx_enable)
  endtask

  task automatic t_mac;
    wr(rb, 16'h1E87);
    @(posedge i_clock);
    `CHK("force_fc", 1'b1, o_flow_ctrl)
    `CHK("bp_on", 1'b1, o_back_pressure)
    `CHK("sniffer", 1'b1, o_sniffer_port)
    wr(rb, 16'h0607);
    @(posedge i_clock);
    `CHK("an_fc0", 1'b0, o_flow_ctrl)
    `CHK("bp_off", 1'b0, o_back_pressure)
    `CHK("normal", 1'b0, o_sniffer_port)
    i_an_flow_ctrl <= 1'b1;
    @(posedge i_clock);
    @(posedge i_clock);
    `CHK("an_fc1", 1'b1, o_flow_ctrl)
  endtask

  initial begin
    repeat (8) @(posedge i_clock);
    i_rst <= 1'b0;
    t_reset();
    t_prio();
    t_egress();
    t_filter();
    t_mac();
    report_and_stop();
  end
endmodule
`default_nettype wire
